// ### common/tplc_pkg.sv
// constants and state types shared by the touch probe latch control block
package tplc_pkg;

    // register byte offsets on the axi4-lite bus
    localparam logic [15:0] TPLC_OFS_CTRL_FIRST  = 16'h2DE0; // probe 1 / probe b
    localparam logic [15:0] TPLC_OFS_CTRL_SECOND = 16'h2DE8; // probe c
    localparam logic [15:0] TPLC_OFS_STATUS      = 16'h2DEC; // latch status
    localparam logic [15:0] TPLC_OFS_ZERO_CFG    = 16'h2DF0; // bit0 linear
    localparam logic [15:0] TPLC_OFS_INTERVAL    = 16'h2DF4; // stop interval
    localparam logic [15:0] TPLC_OFS_LIN_HOME    = 16'h2DFC; // linear home
    localparam logic [15:0] TPLC_OFS_POS_BASE    = 16'h2E00; // 4 positions
    localparam logic [15:0] TPLC_OFS_TS_BASE     = 16'h2E10; // 4 time stamps

    // writable bit masks, reserved bits are dropped and read as zero
    localparam logic [15:0] TPLC_CTRL_FIRST_MASK  = 16'h3737;
    localparam logic [15:0] TPLC_CTRL_SECOND_MASK = 16'h0037;

    // control bit positions, probe b in the first word
    localparam int TPLC_B_EN   = 8;
    localparam int TPLC_B_CONT = 9;
    localparam int TPLC_B_SRC  = 10;
    localparam int TPLC_B_RISE = 12;
    localparam int TPLC_B_FALL = 13;
    // probe c in the second word
    localparam int TPLC_C_EN   = 0;
    localparam int TPLC_C_CONT = 1;
    localparam int TPLC_C_SRC  = 2;
    localparam int TPLC_C_RISE = 4;
    localparam int TPLC_C_FALL = 5;

    // status bit positions; edge index e = 2*probe + fall
    localparam int TPLC_ST_B_EN     = 8;
    localparam int TPLC_ST_C_EN     = 16;
    localparam int TPLC_ST_STORED   = 1;  // +8*(probe+1) +fall
    localparam int TPLC_ST_TOGGLE   = 6;  // +8*(probe+1) +fall

    // reset values
    localparam logic [15:0] TPLC_CTRL_RESET     = 16'h0000;
    localparam logic [31:0] TPLC_INTERVAL_RESET = 32'h0000_0000;

    // time base
    localparam int          TPLC_CLK_PERIOD_PS = 4000;
    localparam logic [31:0] TPLC_TICK_NS  = 32'(TPLC_CLK_PERIOD_PS / 1000);
    localparam int          TPLC_SYNC_STAGES = 2;
    localparam logic [31:0] TPLC_SYNC_LAT_NS =
        32'(TPLC_SYNC_STAGES * TPLC_CLK_PERIOD_PS / 1000);

    // axi responses
    localparam logic [1:0] TPLC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] TPLC_RESP_SLVERR = 2'h2;

    // whole block state, registered in one place
    typedef struct packed {
        logic [15:0]       ctrl1;    // probe_control_first
        logic [15:0]       ctrl2;    // probe_control_second
        logic              linear;   // linear motor zero point mode
        logic [31:0]       interval; // homing_stop_interval_setting
        logic [31:0]       home;     // linear encoder home position
        logic [31:0]       bnd_lo;   // zero point just below position
        logic [31:0]       bnd_hi;   // zero point just above position
        logic              reinit;   // reload the boundaries
        logic [3:0]        stored;   // data stored, per edge
        logic [3:0]        toggle;   // continuous toggle, per edge
        logic [3:0][31:0]  pos_q;    // latched positions
        logic [3:0][31:0]  ts_q;     // latched time stamps
        logic [31:0]       ts_ns;    // free running ns counter
        logic [1:0]        sync1;    // first synchroniser stage
        logic [1:0]        sync2;    // second synchroniser stage
        logic [1:0]        prev;     // last synchronised level
        logic              aw_got;   // write address held
        logic              w_got;    // write data held
        logic [15:0]       awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
    } tplc_state_type;

endpackage : tplc_pkg

// ### logic/tplc_top.sv
// touch probe latch control with axi4-lite register access
//
// Contract
// RQ1: first word bit 8 enables probe b
// RQ2: bit 9 picks single or continuous mode
// RQ3: bit 10 picks input or encoder zero
// RQ4: reserved bits read undefined, host writes zero
// RQ5: bit 12 latches rising position and time
// RQ6: bit 13 latches falling position and time
// RQ7: zero point source stores position only
// RQ8: clearing bit 12 stops rising captures
// RQ9: clearing bit 13 stops falling captures
// RQ10: linear zero points spaced by stop interval
// RQ11: second word bit 0 enables probe c
// RQ12: second word bit 1 sets c mode
// RQ13: second word bit 2 sets c source
// RQ14: stored flag set on latch, cleared disarming
// RQ15: continuous mode toggles status per latch
// RQ16: second word bits 4,5 arm c edges
// RQ17: single mode takes first edge only
`timescale 1ns/10ps
`default_nettype none
module tplc_top
    import tplc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // probe pins, asynchronous
    input  wire logic        probe_input_b,
    input  wire logic        probe_input_c,
    // encoder side, same clock
    input  wire logic [31:0] position_feedback,
    input  wire logic        encoder_zero_mark
);

    tplc_state_type s_r;    // registered state
    tplc_state_type s_nxt;  // next state

    // per edge view of the control words
    logic [3:0] edge_en;    // probe enabled
    logic [3:0] edge_cont;  // continuous mode
    logic [3:0] edge_src;   // 1: encoder zero point
    logic [3:0] edge_arm;   // edge sampling armed
    logic [1:0] rise_det;   // synchronised rising edge per probe
    logic [1:0] fall_det;   // synchronised falling edge per probe
    logic       zero_evt;   // encoder zero point passed
    logic [3:0] cap;        // capture this cycle, per edge
    logic [31:0] stamp;     // time stamp for a pin capture
    logic [31:0] rd_word;   // read mux result
    logic        rd_hit;    // read address mapped
    logic        wr_hit;    // write address mapped
    logic [31:0] wmask;     // byte lane mask from wstrb
    logic [15:0] ctrl1_new; // first word after this cycle's write
    logic [15:0] ctrl2_new; // second word after this cycle's write
    logic        wr_go;     // write performed this cycle

    // axi handshakes are combinational from held flags
    assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
    assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rresp   = s_r.rresp;
    assign s_axi_rdata   = s_r.rdata;

    // map the two control words onto the four edges
    always_comb begin
        edge_en   = {s_r.ctrl2[TPLC_C_EN], s_r.ctrl2[TPLC_C_EN],
                     s_r.ctrl1[TPLC_B_EN], s_r.ctrl1[TPLC_B_EN]};  // [RQ1] [RQ11]
        edge_cont = {s_r.ctrl2[TPLC_C_CONT], s_r.ctrl2[TPLC_C_CONT],
                     s_r.ctrl1[TPLC_B_CONT], s_r.ctrl1[TPLC_B_CONT]}; // [RQ2] [RQ12]
        edge_src  = {s_r.ctrl2[TPLC_C_SRC], s_r.ctrl2[TPLC_C_SRC],
                     s_r.ctrl1[TPLC_B_SRC], s_r.ctrl1[TPLC_B_SRC]};  // [RQ3] [RQ13]
        edge_arm  = {s_r.ctrl2[TPLC_C_FALL], s_r.ctrl2[TPLC_C_RISE],
                     s_r.ctrl1[TPLC_B_FALL], s_r.ctrl1[TPLC_B_RISE]}; // [RQ16]
    end

    // edges are found after the second stage; stage one feeds stage two only
    assign rise_det = s_r.sync2 & ~s_r.prev;
    assign fall_det = ~s_r.sync2 & s_r.prev;

    // the pin edge happened two cycles before it is seen here
    assign stamp = s_r.ts_ns - TPLC_SYNC_LAT_NS;

    // byte lanes of the write data
    assign wmask = {{8{s_r.wstrb[3]}}, {8{s_r.wstrb[2]}},
                    {8{s_r.wstrb[1]}}, {8{s_r.wstrb[0]}}};

    // zero point event: rotary uses the encoder mark, linear the boundaries
    always_comb begin
        zero_evt = 1'b0;
        if (!s_r.linear) begin
            zero_evt = encoder_zero_mark;
        end else if (!s_r.reinit && s_r.interval != 32'h0000_0000) begin
            // one boundary per cycle: axis moves under an interval a clock
            if ($signed(position_feedback) >= $signed(s_r.bnd_hi)) begin
                zero_evt = 1'b1; // [RQ10]
            end else if ($signed(position_feedback) < $signed(s_r.bnd_lo)) begin
                zero_evt = 1'b1; // [RQ10]
            end
        end
    end

    // capture decision per edge
    always_comb begin
        for (int e = 0; e < 4; e++) begin
            logic trig;
            trig = 1'b0;
            if (edge_src[e]) begin
                trig = zero_evt; // [RQ7]
            end else if (e % 2 == 0) begin
                trig = rise_det[e / 2]; // [RQ5]
            end else begin
                trig = fall_det[e / 2]; // [RQ6]
            end
            // disarmed edges take nothing; single mode stops after one
            cap[e] = trig && edge_en[e] && edge_arm[e] // [RQ8] [RQ9]
                     && (edge_cont[e] || !s_r.stored[e]); // [RQ17]
        end
    end

    // read mux; reserved control bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            TPLC_OFS_CTRL_FIRST:  rd_word = {16'h0000, s_r.ctrl1}; // [RQ4]
            TPLC_OFS_CTRL_SECOND: rd_word = {16'h0000, s_r.ctrl2}; // [RQ4]
            TPLC_OFS_STATUS: begin
                rd_word[TPLC_ST_B_EN] = s_r.ctrl1[TPLC_B_EN];
                rd_word[TPLC_ST_C_EN] = s_r.ctrl2[TPLC_C_EN];
                // probe b flags sit at +8, probe c flags at +16
                for (int e = 0; e < 4; e++) begin
                    rd_word[TPLC_ST_STORED + 8 * (e / 2 + 1) + (e % 2)] =
                        s_r.stored[e];
                    rd_word[TPLC_ST_TOGGLE + 8 * (e / 2 + 1) + (e % 2)] =
                        s_r.toggle[e];
                end
            end
            TPLC_OFS_ZERO_CFG: rd_word = {31'h0000_0000, s_r.linear};
            TPLC_OFS_INTERVAL: rd_word = s_r.interval;
            TPLC_OFS_LIN_HOME: rd_word = s_r.home;
            default: begin
                if (s_axi_araddr[15:4] == TPLC_OFS_POS_BASE[15:4]) begin
                    rd_word = s_r.pos_q[s_axi_araddr[3:2]];
                end else if (s_axi_araddr[15:4] == TPLC_OFS_TS_BASE[15:4]) begin
                    rd_word = s_r.ts_q[s_axi_araddr[3:2]];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // control words as they stand after a write in this cycle
    always_comb begin
        wr_go     = s_r.aw_got && s_r.w_got && !s_r.bvalid;
        wr_hit    = 1'b0;
        ctrl1_new = s_r.ctrl1;
        ctrl2_new = s_r.ctrl2;
        unique case (s_r.awaddr)
            TPLC_OFS_CTRL_FIRST: begin
                wr_hit = 1'b1;
                if (wr_go) begin
                    ctrl1_new = (s_r.ctrl1 & ~wmask[15:0])
                        | (s_r.wdata[15:0] & wmask[15:0]
                           & TPLC_CTRL_FIRST_MASK); // [RQ4]
                end
            end
            TPLC_OFS_CTRL_SECOND: begin
                wr_hit = 1'b1;
                if (wr_go) begin
                    ctrl2_new = (s_r.ctrl2 & ~wmask[15:0])
                        | (s_r.wdata[15:0] & wmask[15:0]
                           & TPLC_CTRL_SECOND_MASK); // [RQ4]
                end
            end
            TPLC_OFS_ZERO_CFG, TPLC_OFS_INTERVAL,
            TPLC_OFS_LIN_HOME: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // next state
    always_comb begin
        logic [3:0] arm_new;
        arm_new = {ctrl2_new[TPLC_C_FALL], ctrl2_new[TPLC_C_RISE],
                   ctrl1_new[TPLC_B_FALL], ctrl1_new[TPLC_B_RISE]};
        s_nxt = s_r;

        // time base and synchronisers
        s_nxt.ts_ns = s_r.ts_ns + TPLC_TICK_NS;
        s_nxt.sync1 = {probe_input_c, probe_input_b};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev  = s_r.sync2;

        // zero point boundaries for linear motors
        if (s_r.reinit) begin
            s_nxt.bnd_lo = s_r.home; // [RQ10]
            s_nxt.bnd_hi = s_r.home + s_r.interval;
            s_nxt.reinit = 1'b0;
        end else if (s_r.linear && zero_evt) begin
            if ($signed(position_feedback) >= $signed(s_r.bnd_hi)) begin
                s_nxt.bnd_lo = s_r.bnd_hi; // [RQ10]
                s_nxt.bnd_hi = s_r.bnd_hi + s_r.interval;
            end else begin
                s_nxt.bnd_hi = s_r.bnd_lo; // [RQ10]
                s_nxt.bnd_lo = s_r.bnd_lo - s_r.interval;
            end
        end

        // latches and status; a capture beats a same cycle disarm
        for (int e = 0; e < 4; e++) begin
            if (cap[e]) begin
                s_nxt.pos_q[e] = position_feedback; // [RQ5] [RQ6] [RQ7]
                if (!edge_src[e]) begin
                    s_nxt.ts_q[e] = stamp; // [RQ5] [RQ6]
                end
                if (edge_cont[e]) begin
                    s_nxt.toggle[e] = !s_r.toggle[e]; // [RQ15]
                end
            end
            s_nxt.stored[e] = cap[e] || (s_r.stored[e] && arm_new[e]); // [RQ14]
        end

        // write channel: take address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        s_nxt.ctrl1 = ctrl1_new;
        s_nxt.ctrl2 = ctrl2_new;
        if (wr_go) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = wr_hit ? TPLC_RESP_OKAY : TPLC_RESP_SLVERR;
            unique case (s_r.awaddr)
                TPLC_OFS_ZERO_CFG: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.linear = s_r.wdata[0];
                    end
                    s_nxt.reinit = 1'b1;
                end
                TPLC_OFS_INTERVAL: begin
                    s_nxt.interval = (s_r.interval & ~wmask)
                                     | (s_r.wdata & wmask);
                    s_nxt.reinit   = 1'b1; // new spacing, new boundaries
                end
                TPLC_OFS_LIN_HOME: begin
                    s_nxt.home   = (s_r.home & ~wmask) | (s_r.wdata & wmask);
                    s_nxt.reinit = 1'b1;
                end
                default: ;
            endcase
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // read channel: one cycle from address to data
        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = rd_word;
            s_nxt.rresp  = rd_hit ? TPLC_RESP_OKAY : TPLC_RESP_SLVERR;
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    // state register, synchronous active low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r          <= '0;
            s_r.ctrl1    <= TPLC_CTRL_RESET;
            s_r.ctrl2    <= TPLC_CTRL_RESET;
            s_r.interval <= TPLC_INTERVAL_RESET;
            s_r.reinit   <= 1'b1; // boundaries load right after reset
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : tplc_top
`default_nettype wire

// ### tb/tplc_assertions.sv
// concurrent checks on the register bus side of the latch block
`timescale 1ns/10ps
`default_nettype none
module tplc_assertions
    import tplc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [15:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // read address and joint write handshakes
    wire rd_go = s_axi_arvalid && s_axi_arready;
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    property p_rd_lat; rd_go |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("late read answer");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block)
        else $error("read taken while busy");
    property p_rd_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rd_once: assert property (p_rd_once)
        else $error("read answer repeated");
    // held, performed, answered two edges later
    property p_wr_lat; wr_go |-> ##2 s_axi_bvalid; endproperty
    a_wr_lat: assert property (p_wr_lat)
        else $error("late write answer");
    property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_block: assert property (p_w_block)
        else $error("write taken while busy");
    // reserved control bits never read back as ones
    property p_c1_rsv; rd_go && s_axi_araddr == TPLC_OFS_CTRL_FIRST |=>
        (s_axi_rdata & ~{16'h0000, TPLC_CTRL_FIRST_MASK}) == '0;
    endproperty
    a_c1_rsv: assert property (p_c1_rsv)
        else $error("first word reserved bits");
    property p_c2_rsv; rd_go && s_axi_araddr == TPLC_OFS_CTRL_SECOND |=>
        (s_axi_rdata & ~{16'h0000, TPLC_CTRL_SECOND_MASK}) == '0
        && s_axi_rresp == TPLC_RESP_OKAY;
    endproperty
    a_c2_rsv: assert property (p_c2_rsv)
        else $error("second word reserved bits");
    property p_unmapped; rd_go && s_axi_araddr == 16'h0000 |=>
        s_axi_rresp == TPLC_RESP_SLVERR && s_axi_rdata == '0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read accepted");
    c_write: cover property (wr_go);
    c_read: cover property (rd_go ##1 s_axi_rvalid);
    c_hole: cover property (rd_go && s_axi_araddr == 16'h0000);
endmodule : tplc_assertions

bind tplc_top tplc_assertions chk_u (.*);
`default_nettype wire

// ### tb/tplc_probe_model.sv
// model of the probe pins and the position encoder facing the block
`timescale 1ns/10ps
`default_nettype none
module tplc_probe_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        lvl_b,
    input  wire logic        lvl_c,
    input  wire logic [31:0] pos_cmd,
    input  wire logic        zero_cmd,
    output logic             probe_input_b,
    output logic             probe_input_c,
    output logic [31:0]      position_feedback,
    output logic             encoder_zero_mark
);
    // pins start low so the block sees a defined level from time zero
    initial begin
        probe_input_b = 1'h0;
        probe_input_c = 1'h0;
        position_feedback = 32'h0000_0000;
        encoder_zero_mark = 1'h0;
    end
    // pins move right after an edge; the block still has to synchronise
    always @(posedge aclk) begin
        probe_input_b <= lvl_b;
        probe_input_c <= lvl_c;
        position_feedback <= pos_cmd;
        // zero point mark is a single cycle pulse, none in reset
        encoder_zero_mark <= zero_cmd && aresetn;
    end
endmodule : tplc_probe_model
`default_nettype wire

// ### tb/test_touch_probe_latch_control.sv
// self checking bench of the touch probe latch control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_count++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module test_touch_probe_latch_control import tplc_pkg::*;;
    localparam logic [15:0] C1 = TPLC_OFS_CTRL_FIRST;
    localparam logic [15:0] C2 = TPLC_OFS_CTRL_SECOND;
    localparam logic [15:0] ST = TPLC_OFS_STATUS;
    localparam logic [15:0] P  = TPLC_OFS_POS_BASE;
    localparam logic [15:0] T  = TPLC_OFS_TS_BASE;
    localparam logic [1:0]  OK = TPLC_RESP_OKAY;
    localparam logic [1:0]  SE = TPLC_RESP_SLVERR;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam int          GAP = 20; // cycles between probe edges
    localparam logic [31:0] GAP_NS = 32'(GAP) * TPLC_TICK_NS;
    localparam int          NROW = 7;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0, lvl_b = 1'h0;
    logic        lvl_c = 1'h0, zero_cmd = 1'h0;
    logic [31:0] wdata = 32'h0000_0000, pos_cmd = 32'h0000_0000;
    logic [3:0]  wstrb = 4'hF;
    logic        awready, wready, bvalid, arready, rvalid, pin_b, pin_c, zm;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, pos_fb, data, ts_r;
    int          err_count = 0, check_count = 0;
    // one register case: write, then read back with expected answers
    typedef struct packed {
        logic [15:0] wa;
        logic [31:0] wd;
        logic [15:0] ra;
        logic [31:0] rd;
        logic [1:0]  br;
        logic [1:0]  rr;
    } tplc_row_type;
    tplc_row_type rows [NROW] = '{
        '{C1, 32'hFFFF, C1, 32'h3737, OK, OK},
        '{C2, 32'hFFFF, C2, 32'h0037, OK, OK},
        '{C1, 32'h0100, ST, 32'h0001_0100, OK, OK},
        '{C2, 32'h0, ST, 32'h0100, OK, OK},
        '{C1, 32'h0, ST, 32'h0, OK, OK},
        '{TPLC_OFS_INTERVAL, 32'h64, TPLC_OFS_INTERVAL, 32'h64, OK, OK},
        '{16'h0, 32'h1234, 16'h0, 32'h0, SE, SE}};

    always #2 aclk = ~aclk;

    tplc_top dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .probe_input_b(pin_b),
        .probe_input_c(pin_c), .position_feedback(pos_fb),
        .encoder_zero_mark(zm));
    tplc_probe_model model_u (
        .aclk(aclk), .aresetn(aresetn), .lvl_b(lvl_b), .lvl_c(lvl_c),
        .pos_cmd(pos_cmd), .zero_cmd(zero_cmd), .probe_input_b(pin_b),
        .probe_input_c(pin_c), .position_feedback(pos_fb),
        .encoder_zero_mark(zm));

    // write: both halves offered together, each dropped once taken
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask : axi_wr
    // read: address held until taken, answer taken at its own edge
    task automatic axi_rd(input logic [15:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : axi_rd
    task automatic rd_chk(input string nm, input logic [15:0] a,
                          input logic [31:0] e, input logic [31:0] m = ALL);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        `CHK(nm, e, d & m)
        `CHK(nm, OK, r)
    endtask : rd_chk
    // rise with position pr, fall GAP cycles later with position pf
    task automatic pulse(input bit c, input logic [31:0] pr,
                         input logic [31:0] pf);
        @(posedge aclk);
        pos_cmd <= pr;
        if (c) lvl_c <= 1'h1; else lvl_b <= 1'h1;
        repeat (GAP) @(posedge aclk);
        pos_cmd <= pf;
        if (c) lvl_c <= 1'h0; else lvl_b <= 1'h0;
        repeat (GAP) @(posedge aclk);
    endtask : pulse
    task automatic zero(input logic [31:0] p);
        @(posedge aclk);
        pos_cmd <= p;
        zero_cmd <= 1'h1;
        @(posedge aclk);
        zero_cmd <= 1'h0;
        repeat (4) @(posedge aclk);
    endtask : zero
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // watchdog: the whole run needs under 500 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        conclude();
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < NROW; i++) begin
            axi_wr(rows[i].wa, rows[i].wd, resp);
            `CHK("bresp", rows[i].br, resp)
            axi_rd(rows[i].ra, data, resp);
            `CHK("rdata", rows[i].rd, data)
            `CHK("rresp", rows[i].rr, resp)
        end
        $display("test register rows done");
        // probe b continuous on its pin, both edges, twice
        axi_wr(C1, 32'h3300, resp);
        pulse(1'h0, 32'h1234, 32'h5678);
        rd_chk("b rise pos", P, 32'h1234);
        rd_chk("b fall pos", P + 16'h4, 32'h5678);
        axi_rd(T, ts_r, resp);
        axi_rd(T + 16'h4, data, resp);
        `CHK("stamp gap", GAP_NS, data - ts_r)
        rd_chk("b status", ST, 32'hC700);
        pulse(1'h0, 32'h2222, 32'h3333);
        rd_chk("b rise again", P, 32'h2222);
        rd_chk("b toggles", ST, 32'h0700);
        axi_rd(T, ts_r, resp);
        $display("test continuous done");
        // probe c single mode, rise only: second edge must be ignored
        axi_wr(C2, 32'h11, resp);
        pulse(1'h1, 32'hAAAA, 32'hCCCC);
        pulse(1'h1, 32'hBBBB, 32'hCCCC);
        rd_chk("c rise pos", P + 16'h8, 32'hAAAA);
        rd_chk("c fall pos", P + 16'hC, 32'h0);
        rd_chk("c status", ST, 32'h0003_0000, 32'h00FF_0000);
        $display("test single done");
        // disarming clears stored flags and stops capture
        axi_wr(C1, 32'h0300, resp);
        rd_chk("b stored clr", ST, 32'h0, 32'h0600);
        pulse(1'h0, 32'h9999, 32'h9999);
        rd_chk("b rise kept", P, 32'h2222);
        rd_chk("b fall kept", P + 16'h4, 32'h3333);
        axi_wr(C1, 32'h3200, resp);
        pulse(1'h0, 32'h7777, 32'h7777);
        rd_chk("b disabled", P, 32'h2222);
        $display("test disarm done");
        // zero point source: pin ignored, position only, no stamp
        axi_wr(C1, 32'h1700, resp);
        pulse(1'h0, 32'h0888, 32'h0888);
        rd_chk("pin ignored", P, 32'h2222);
        zero(32'h0777);
        rd_chk("zero pos", P, 32'h0777);
        rd_chk("zero no stamp", T, ts_r);
        axi_wr(C2, 32'h0, resp);
        axi_wr(C2, 32'h17, resp);
        zero(32'h0555);
        rd_chk("c zero pos", P + 16'h8, 32'h0555);
        // linear: park below home + interval, then crossing it captures
        zero(32'h0010);
        axi_wr(TPLC_OFS_ZERO_CFG, 32'h1, resp);
        zero(32'h0070);
        rd_chk("linear zero", P, 32'h0070);
        $display("test zero point done");
        // reset in mid run clears control, status and latches
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rd_chk("ctrl reset", C1, 32'h0);
        rd_chk("status reset", ST, 32'h0);
        rd_chk("latch reset", P, 32'h0);
        $display("test reset done");
        conclude();
    end
endmodule : test_touch_probe_latch_control
`default_nettype wire
